// ===== design/hcdp_cfg.svh
// Constants for the host command and data path.
// Assumes inclusion by bare name from design files only.
`ifndef HCDP_CFG_SVH
`define HCDP_CFG_SVH
`define HCDP_RXF_DEPTH 64
`define HCDP_RXF_AW 6
`define HCDP_IFF_DEPTH 8
`define HCDP_IFF_AW 3
`define HCDP_PIXF_DEPTH 128
`define HCDP_PIXF_AW 7
`define HCDP_CTL_BOARD 3'h1
`define HCDP_CMD_LSB 30
`define HCDP_BOARD_LSB 16
`define HCDP_RD_WAIT 2'h2
`define HCDP_SYNC_WORD 32'h5a5a0000
`define HCDP_ASYNC_STATUS 32'ha5a50001
`define HCDP_PGM_LO 16'h1000
`define HCDP_PGM_HI 16'h1bff
`endif

// ===== design/hcdp_pkg.sv
// Types for the host command and data path.
// Assumes hcdp_cfg.svh is on the include path.
package hcdp_pkg;
  typedef enum logic [1:0] {
    HCDP_CMD_ASYNC = 2'h0,
    HCDP_CMD_WRITE = 2'h1,
    HCDP_CMD_READ = 2'h2,
    HCDP_CMD_START = 2'h3
  } hcdp_cmd_e;
  typedef enum logic [4:0] {
    HCDP_ST_IDLE = 5'h01,
    HCDP_ST_DEC = 5'h02,
    HCDP_ST_RDADDR = 5'h04,
    HCDP_ST_RDWAIT = 5'h08,
    HCDP_ST_RDCAP = 5'h10
  } hcdp_state_e;
endpackage

// ===== design/hcdp_fifo.sv
// Small synchronous FIFO with registered read data.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module hcdp_fifo #(
  parameter int W = 32,
  parameter int AW = 3
) (
  input wire logic ref_clk_i, // Clock
  input wire logic sys_rst_i, // Sync reset
  input wire logic push_i, // Write request
  input wire logic [W-1:0] wdata_i, // Write data
  input wire logic pop_i, // Read request
  output logic [W-1:0] rdata_o, // Read data, valid after pop
  output logic full_o, // Full
  output logic empty_o // Empty
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  wire do_push = push_i && !full_o;
  wire do_pop = pop_i && !empty_o;
  assign empty_o = (wp_reg == rp_reg);
  assign full_o = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wp_reg[AW-1:0]] <= wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      rdata_o <= '0;
    end else begin
      if (do_push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_pop) begin
        rp_reg <= rp_reg + 1'b1;
        rdata_o <= mem[rp_reg[AW-1:0]];
      end
    end
  end
endmodule

// ===== design/hcdp_top.sv
// Host command and data path: receive, echo, decode, route, pixel out.
// Assumes all inputs synchronous to ref_clk_i; host sends async first.
`timescale 1ns/1ps
`include "hcdp_cfg.svh"
module hcdp_top (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic sys_rst_i, // Sync reset, active high
  input wire logic link_rx_valid_i, // Host word present
  input wire logic [31:0] link_rx_data_i, // Host word
  output logic link_rx_ready_o, // Host word accepted
  output logic link_tx_valid_o, // Word to host valid
  output logic [31:0] link_tx_data_o, // Word to host
  output logic link_tx_sync_o, // Word is a message
  input wire logic link_tx_ready_i, // Host link ready
  input wire logic seq_bus_owned_i, // Sequencer owns bus
  input wire logic seq_enabled_i, // Sequencer enabled
  output logic seq_bus_sel_o, // Bus transaction strobe
  output logic seq_bus_read_o, // Transaction is a read
  output logic [2:0] seq_bus_board_o, // Addressed board
  output logic [31:0] seq_bus_data_o, // Bus data
  input wire logic [47:0] pixel_bus_word_i, // Pixel bus
  input wire logic pixel_burst_i, // Peripheral burst strobe
  input wire logic double_pixel_enable_i, // Pack two pixels
  output logic pixel_fifo_capture_strobe_o, // Read capture strobe
  output logic pixel_fifo_full_o, // Pixel FIFO full
  output logic local_wr_o, // Local register write
  output logic [15:0] local_addr_o, // Local address
  output logic [31:0] local_wdata_o, // Local write data
  input wire logic [31:0] local_rdata_i, // Local read data
  output logic [15:0] interface_data_o, // Inter-FPGA data
  output logic interface_ctl_line_a_o, // Half valid
  output logic interface_ctl_line_b_o, // High half marker
  output logic interface_ctl_line_c_o, // Direction, fixed outbound
  output logic start_exposure_o, // Start pulse
  output logic [7:0] start_vector_o, // Start vector
  output logic access_denied_o // Program memory denial pulse
);
  import hcdp_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic in_pgm(input logic [15:0] a);
    in_pgm = (a >= `HCDP_PGM_LO) && (a <= `HCDP_PGM_HI);
  endfunction

  hcdp_state_e st_reg, st_next;
  logic synced_reg;
  logic reset_reply_reg;
  logic [31:0] cmd_word;
  logic [1:0] wait_reg;
  logic rxf_full, rxf_empty;
  logic [31:0] rxf_rdata;
  logic rxf_pop;
  logic rx_ok;
  logic echo_pend_reg;
  // The echo slot holds one word, so the host waits while it is occupied.
  assign link_rx_ready_o = !rxf_full && !echo_pend_reg;
  assign rx_ok = link_rx_valid_i && link_rx_ready_o;
  hcdp_fifo #(.W(32), .AW(`HCDP_RXF_AW)) u_rxf (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .push_i(rx_ok), .wdata_i(link_rx_data_i), .pop_i(rxf_pop),
    .rdata_o(rxf_rdata), .full_o(rxf_full), .empty_o(rxf_empty));

  ////////////////////////////////////////////////////////////////////////
  // Echo path: the echo has priority over pixel data on the link.
  logic [31:0] echo_reg;
  logic echo_take;
  assign echo_take = rx_ok && !echo_pend_reg;
  // Host words only enter when the echo slot is free, so none are lost.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      echo_pend_reg <= 1'b0;
      echo_reg <= 32'h00000000;
      reset_reply_reg <= 1'b1;
    end else begin
      if (echo_take) begin
        echo_pend_reg <= 1'b1;
        echo_reg <= reset_reply_reg ? `HCDP_ASYNC_STATUS : link_rx_data_i;
        reset_reply_reg <= 1'b0;
      end else if (echo_pend_reg && !(link_tx_valid_o && !link_tx_ready_i)) begin
        // Freed only when the transmit stage loads it, so no echo is sent twice
        echo_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interface toward the pixel side: words split into 16-bit halves.
  logic iff_push, iff_pop, iff_full, iff_empty;
  logic [31:0] iff_wdata, iff_rdata;
  logic half_reg, have_reg;
  hcdp_fifo #(.W(32), .AW(`HCDP_IFF_AW)) u_iff (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .push_i(iff_push), .wdata_i(iff_wdata), .pop_i(iff_pop),
    .rdata_o(iff_rdata), .full_o(iff_full), .empty_o(iff_empty));
  assign iff_pop = !have_reg && !iff_empty;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      have_reg <= 1'b0;
      half_reg <= 1'b0;
    end else if (iff_pop) begin
      have_reg <= 1'b1;
      half_reg <= 1'b0;
    end else if (have_reg) begin
      half_reg <= !half_reg;
      have_reg <= !half_reg;
    end
  end
  assign interface_ctl_line_a_o = have_reg;
  assign interface_ctl_line_b_o = half_reg;
  assign interface_ctl_line_c_o = 1'b0;
  assign interface_data_o = half_reg ? iff_rdata[31:16] : iff_rdata[15:0];

  // Pixel-side reassembly of halves into words, low half first.
  logic [15:0] lo_reg;
  logic [31:0] pif_word;
  logic pif_push, pif_pop, pif_full, pif_empty;
  logic [31:0] pif_rdata;
  assign pif_word = {interface_data_o, lo_reg};
  assign pif_push = interface_ctl_line_a_o && interface_ctl_line_b_o;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      lo_reg <= 16'h0000;
    end else if (interface_ctl_line_a_o && !interface_ctl_line_b_o) begin
      lo_reg <= interface_data_o;
    end
  end
  hcdp_fifo #(.W(32), .AW(`HCDP_IFF_AW)) u_pif (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .push_i(pif_push), .wdata_i(pif_word), .pop_i(pif_pop),
    .rdata_o(pif_rdata), .full_o(pif_full), .empty_o(pif_empty));

  ////////////////////////////////////////////////////////////////////////
  // Command decoder.
  hcdp_cmd_e cmd_kind;
  logic [2:0] cmd_board;
  logic [15:0] cmd_addr;
  logic cmd_local, stall, iff_room;
  // FIFO read data stands from one pop to the next, and only IDLE pops.
  assign cmd_word = rxf_rdata;
  assign cmd_kind = hcdp_cmd_e'(cmd_word[`HCDP_CMD_LSB +: 2]);
  assign cmd_board = cmd_word[`HCDP_BOARD_LSB +: 3];
  assign cmd_addr = cmd_word[15:0];
  assign cmd_local = (cmd_board == `HCDP_CTL_BOARD);
  assign stall = seq_bus_owned_i;
  // Every synced command needs interface room; that stall comes before the word.
  assign iff_room = !iff_full && !pif_full;
  assign rxf_pop = (st_reg == HCDP_ST_IDLE) && !rxf_empty;
  logic deny;
  assign deny = seq_enabled_i && cmd_local && in_pgm(cmd_addr);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      HCDP_ST_IDLE: begin
        if (!rxf_empty) begin
          st_next = HCDP_ST_DEC;
        end
      end
      HCDP_ST_DEC: begin
        if (!synced_reg) begin
          st_next = HCDP_ST_IDLE;
        end else if (stall || !iff_room) begin
          st_next = HCDP_ST_DEC;
        end else if (cmd_kind == HCDP_CMD_READ && !cmd_local && !deny) begin
          st_next = HCDP_ST_RDADDR;
        end else begin
          st_next = HCDP_ST_IDLE;
        end
      end
      HCDP_ST_RDADDR: st_next = HCDP_ST_RDWAIT;
      HCDP_ST_RDWAIT: begin
        if (wait_reg == `HCDP_RD_WAIT - 2'h1) begin
          st_next = HCDP_ST_RDCAP;
        end
      end
      HCDP_ST_RDCAP: st_next = HCDP_ST_IDLE;
      default: st_next = HCDP_ST_IDLE;
    endcase
  end

  logic dec_go;
  assign dec_go = (st_reg == HCDP_ST_DEC) && synced_reg && !stall && iff_room;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= HCDP_ST_IDLE;
      synced_reg <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      if (st_reg == HCDP_ST_DEC && cmd_kind == HCDP_CMD_ASYNC) begin
        synced_reg <= 1'b1;
      end
      wait_reg <= (st_reg == HCDP_ST_RDWAIT) ? wait_reg + 2'h1 : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs of a decoded command.
  logic is_wr, is_rd, is_st;
  assign is_wr = dec_go && cmd_kind == HCDP_CMD_WRITE && !deny;
  assign is_rd = dec_go && cmd_kind == HCDP_CMD_READ && !deny;
  assign is_st = dec_go && cmd_kind == HCDP_CMD_START;
  // every host word goes to the interface except an unsynced one meeting a full FIFO; local read data follows.
  assign iff_push = (st_reg == HCDP_ST_DEC) && (dec_go || !synced_reg) && !iff_full;
  assign iff_wdata = cmd_word;
  logic rd_ret_reg;
  logic [31:0] rd_data_reg;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      seq_bus_sel_o <= 1'b0;
      seq_bus_read_o <= 1'b0;
      seq_bus_board_o <= 3'h0;
      seq_bus_data_o <= 32'h00000000;
      local_wr_o <= 1'b0;
      local_addr_o <= 16'h0000;
      local_wdata_o <= 32'h00000000;
      start_exposure_o <= 1'b0;
      start_vector_o <= 8'h00;
      access_denied_o <= 1'b0;
      rd_ret_reg <= 1'b0;
      rd_data_reg <= 32'h00000000;
    end else begin
      seq_bus_sel_o <= (is_wr && !cmd_local) || (st_reg == HCDP_ST_RDADDR);
      seq_bus_read_o <= (st_reg == HCDP_ST_RDADDR);
      seq_bus_board_o <= cmd_board;
      seq_bus_data_o <= (st_reg == HCDP_ST_RDADDR) ? {16'h0000, cmd_addr} : cmd_word;
      local_wr_o <= is_wr && cmd_local;
      local_addr_o <= cmd_addr;
      local_wdata_o <= cmd_word;
      start_exposure_o <= is_st;
      start_vector_o <= cmd_word[7:0];
      access_denied_o <= dec_go && deny && cmd_kind != HCDP_CMD_START;
      rd_ret_reg <= is_rd && cmd_local;
      // Held until the next local read is decoded; the local bus moves on meanwhile
      rd_data_reg <= (is_rd && cmd_local) ? local_rdata_i : rd_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel bus FIFO: read captures and bursts.
  logic [47:0] pxf_rdata;
  logic pxf_push, pxf_pop, pxf_empty;
  assign pixel_fifo_capture_strobe_o = (st_reg == HCDP_ST_RDCAP);
  assign pxf_push = pixel_fifo_capture_strobe_o || pixel_burst_i;
  hcdp_fifo #(.W(48), .AW(`HCDP_PIXF_AW)) u_pxf (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .push_i(pxf_push), .wdata_i(pixel_bus_word_i), .pop_i(pxf_pop),
    .rdata_o(pxf_rdata), .full_o(pixel_fifo_full_o), .empty_o(pxf_empty));

  // Link transmit stage: one output register, no FIFO of its own.
  logic tx_busy;
  logic pxv_reg, pif_v_reg;
  assign tx_busy = link_tx_valid_o && !link_tx_ready_i;
  assign pxf_pop = !pxv_reg && !pxf_empty && !pif_v_reg;
  assign pif_pop = !pif_v_reg && !pif_empty && !pxv_reg;
  logic [31:0] pix_word;
  assign pix_word = double_pixel_enable_i ? {pxf_rdata[39:24], pxf_rdata[15:0]}
                                          : {8'h00, pxf_rdata[23:0]};
  // Returned words are either echoes to drop or local read data to send.
  logic rd_wait_reg;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      link_tx_valid_o <= 1'b0;
      link_tx_data_o <= 32'h00000000;
      link_tx_sync_o <= 1'b0;
      pxv_reg <= 1'b0;
      pif_v_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
    end else begin
      if (pxf_pop) begin
        pxv_reg <= 1'b1;
      end
      if (pif_pop) begin
        pif_v_reg <= 1'b1;
      end
      if (rd_ret_reg) begin
        rd_wait_reg <= 1'b1;
      end
      if (!tx_busy) begin
        link_tx_valid_o <= 1'b0;
        link_tx_sync_o <= 1'b0;
        if (echo_pend_reg) begin
          link_tx_valid_o <= 1'b1;
          link_tx_sync_o <= 1'b1;
          link_tx_data_o <= echo_reg;
        end else if (pif_v_reg) begin
          pif_v_reg <= 1'b0;
          if (rd_wait_reg) begin
            link_tx_valid_o <= 1'b1;
            link_tx_sync_o <= 1'b1;
            link_tx_data_o <= rd_data_reg;
            rd_wait_reg <= rd_ret_reg;
          end
        end else if (pxv_reg) begin
          pxv_reg <= 1'b0;
          link_tx_valid_o <= 1'b1;
          link_tx_data_o <= pix_word;
        end
      end
    end
  end
endmodule

// ===== test/hcdp_checker.sv
// Concurrent checks on the ports of the host command and data path.
// Assumes it is bound to hcdp_top and shares its clock and reset.
`timescale 1ns/1ps
module hcdp_checker (
  input wire logic ref_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic seq_bus_owned_i, // Sequencer owns bus
  input wire logic seq_enabled_i, // Sequencer enabled
  input wire logic link_tx_ready_i, // Host ready
  input wire logic link_tx_valid_o, // Word to host valid
  input wire logic [31:0] link_tx_data_o, // Word to host
  input wire logic link_tx_sync_o, // Message flag
  input wire logic seq_bus_sel_o, // Bus strobe
  input wire logic seq_bus_read_o, // Bus read
  input wire logic pixel_fifo_capture_strobe_o, // Capture strobe
  input wire logic local_wr_o, // Local write
  input wire logic interface_ctl_line_a_o, // Half valid
  input wire logic interface_ctl_line_b_o, // High half
  input wire logic interface_ctl_line_c_o, // Direction
  input wire logic access_denied_o // Denial pulse
);
  logic low_half;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  assign low_half = interface_ctl_line_a_o && !interface_ctl_line_b_o;
  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral needs two quiet cycles before the capture strobe
  sequence s_rd_issue;
    seq_bus_sel_o && seq_bus_read_o;
  endsequence
  sequence s_rd_settle;
    !pixel_fifo_capture_strobe_o [*2] ##[0:2] pixel_fifo_capture_strobe_o;
  endsequence
  AST_RD_CAPTURE: assert property (s_rd_issue |-> s_rd_settle)
    else $error("read capture strobe out of place");
  AST_DIR_OUT: assert property (interface_ctl_line_c_o == 1'b0)
    else $error("interface direction not outbound");
  AST_HALF_ORDER: assert property (low_half |=> interface_ctl_line_a_o && interface_ctl_line_b_o)
    else $error("high half did not follow low half");
  AST_HIGH_PREV: assert property (interface_ctl_line_a_o && interface_ctl_line_b_o |-> $past(low_half))
    else $error("high half without low half");
  AST_SEL_PULSE: assert property (seq_bus_sel_o |=> !seq_bus_sel_o)
    else $error("bus strobe longer than one cycle");
  AST_STALL: assert property (seq_bus_owned_i [*2] |-> !seq_bus_sel_o && !local_wr_o)
    else $error("host access while sequencer owns bus");
  AST_DENY: assert property (access_denied_o |-> $past(seq_enabled_i) && !local_wr_o)
    else $error("denial without sequencer enabled");
  AST_TX_HOLD: assert property (link_tx_valid_o && !link_tx_ready_i |=>
    link_tx_valid_o && $stable(link_tx_data_o) && $stable(link_tx_sync_o))
    else $error("host word dropped while link stalled");
  AST_LOCAL_NO_BUS: assert property (local_wr_o |-> !seq_bus_sel_o)
    else $error("local write reached the bus");
endmodule
bind hcdp_top hcdp_checker u_chk (.ref_clk_i, .sys_rst_i, .seq_bus_owned_i, .seq_enabled_i,
  .link_tx_ready_i, .link_tx_valid_o, .link_tx_data_o, .link_tx_sync_o, .seq_bus_sel_o,
  .seq_bus_read_o, .pixel_fifo_capture_strobe_o, .local_wr_o, .interface_ctl_line_a_o,
  .interface_ctl_line_b_o, .interface_ctl_line_c_o, .access_denied_o);

// ===== test/hcdp_host_model.sv
// Host computer at the far end of the fibre link.
// Assumes the bench calls send() and reads timeouts at the close.
`timescale 1ns/1ps
module hcdp_host_model (
  input wire logic ref_clk_i, // Clock
  input wire logic rx_ready_i, // Device took the word
  output logic rx_valid_o, // Word present
  output logic [31:0] rx_data_o, // Word
  output logic tx_ready_o // Host accepting
);
  int timeouts = 0;
  logic [1:0] slot = 2'h0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 32'h0;
    tx_ready_o = 1'b1;
  end
  // Host stalls one cycle in four so held words are exercised
  always @(posedge ref_clk_i) begin
    slot <= slot + 2'h1;
    tx_ready_o <= (slot != 2'h3);
  end
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rx_ready_i !== 1'b1 && n < 200);
    if (rx_ready_i !== 1'b1) timeouts++;
    rx_valid_o <= 1'b0;
    // Released line shows the inverse so a stale word is never taken for data
    rx_data_o <= ~w;
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the host command and data path.
// Assumes the host model on the link and the checker bound to the top.
`timescale 1ns/1ps
module tb_top;
  import hcdp_pkg::*;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, link_rx_valid_i, link_tx_ready_i;
  logic seq_bus_owned_i = 1'b0, seq_enabled_i = 1'b0, pixel_burst_i = 1'b0;
  logic double_pixel_enable_i = 1'b0, rd_hold = 1'b0;
  logic [31:0] link_rx_data_i, local_rdata_i = 32'h0;
  logic [47:0] pixel_bus_word_i = 48'h0;
  logic link_rx_ready_o, link_tx_valid_o, link_tx_sync_o, seq_bus_sel_o, seq_bus_read_o;
  logic pixel_fifo_capture_strobe_o, pixel_fifo_full_o, local_wr_o, start_exposure_o;
  logic interface_ctl_line_a_o, interface_ctl_line_b_o, interface_ctl_line_c_o;
  logic access_denied_o;
  logic [31:0] link_tx_data_o, seq_bus_data_o, local_wdata_o;
  logic [2:0] seq_bus_board_o;
  logic [15:0] local_addr_o, interface_data_o, lo_half;
  logic [7:0] start_vector_o;
  logic [47:0] q_echo[$], q_pix[$], q_bus[$], q_loc[$], q_st[$], q_den[$], q_if[$];
  logic [63:0] nxt;
  int fails = 0, n_compared = 0;
  hcdp_top uut (.ref_clk_i, .sys_rst_i, .link_rx_valid_i, .link_rx_data_i, .link_rx_ready_o,
    .link_tx_valid_o, .link_tx_data_o, .link_tx_sync_o, .link_tx_ready_i, .seq_bus_owned_i,
    .seq_enabled_i, .seq_bus_sel_o, .seq_bus_read_o, .seq_bus_board_o, .seq_bus_data_o,
    .pixel_bus_word_i, .pixel_burst_i, .double_pixel_enable_i, .pixel_fifo_capture_strobe_o,
    .pixel_fifo_full_o, .local_wr_o, .local_addr_o, .local_wdata_o, .local_rdata_i,
    .interface_data_o, .interface_ctl_line_a_o, .interface_ctl_line_b_o,
    .interface_ctl_line_c_o, .start_exposure_o, .start_vector_o, .access_denied_o);
  hcdp_host_model host (.ref_clk_i, .rx_ready_i(link_rx_ready_o), .rx_valid_o(link_rx_valid_i),
    .rx_data_o(link_rx_data_i), .tx_ready_o(link_tx_ready_i));
  always #12.5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] cw(hcdp_cmd_e k, logic [2:0] b, logic [15:0] a);
    return {k, 11'h0, b, a};
  endfunction
  function automatic logic [47:0] pix32(logic [47:0] w, logic d);
    return d ? {16'h0, w[39:24], w[15:0]} : {24'h0, w[23:0]};
  endfunction
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // An unexpected result meets an empty queue and is compared with its own inverse
  task automatic take(ref logic [47:0] q[$], input logic [47:0] seen, input string nm);
    check(nm, seen, (q.size() > 0) ? q.pop_front() : ~seen);
  endtask
  task automatic end_of_test();
    fails += host.timeouts;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hs(input logic [31:0] w);
    q_echo.push_back({16'h0, w});
    q_if.push_back({16'h0, w});
    host.send(w);
    if (host.timeouts != 0) end_of_test();
  endtask
  task automatic wait_drain();
    int n;
    n = 0;
    while (q_echo.size() + q_pix.size() + q_bus.size() + q_loc.size() + q_st.size()
      + q_den.size() + q_if.size() != 0 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      end_of_test();
    end
    repeat (10) @(posedge ref_clk_i);
    check("idle", {46'h0, link_rx_ready_o, pixel_fifo_full_o}, 48'h2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    if (!rd_hold) local_rdata_i <= $urandom;
    if (!sys_rst_i) begin
      if (link_tx_valid_o === 1'b1 && link_tx_ready_i === 1'b1) begin
        if (link_tx_sync_o === 1'b1) take(q_echo, {16'h0, link_tx_data_o}, "echo");
        else take(q_pix, {16'h0, link_tx_data_o}, "pixel");
      end
      if (seq_bus_sel_o === 1'b1) begin
        take(q_bus, {12'h0, seq_bus_read_o, seq_bus_board_o, seq_bus_data_o}, "bus");
        if (seq_bus_read_o === 1'b1) begin
          nxt = {$urandom, $urandom};
          pixel_bus_word_i <= nxt[47:0];
          q_pix.push_back(pix32(nxt[47:0], double_pixel_enable_i));
        end
      end
      if (local_wr_o === 1'b1) take(q_loc, {local_addr_o, local_wdata_o}, "local");
      if (interface_ctl_line_a_o === 1'b1 && interface_ctl_line_b_o === 1'b1) begin
        take(q_if, {16'h0, interface_data_o, lo_half}, "iface");
      end
      if (interface_ctl_line_a_o === 1'b1 && interface_ctl_line_b_o === 1'b0) begin
        lo_half <= interface_data_o;
      end
      if (start_exposure_o === 1'b1) take(q_st, {40'h0, start_vector_o}, "start");
      if (access_denied_o === 1'b1) take(q_den, 48'h1, "deny");
    end
  end
  initial begin
    logic [15:0] a;
    logic [47:0] bw;
    logic [15:0] lcl [4];
    void'($urandom(1529));
    lcl = '{16'h0fff, 16'h1000, 16'h1bff, 16'h1c00};
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    q_echo.push_back(48'ha5a50001);
    q_if.push_back({16'h0, cw(HCDP_CMD_WRITE, 3'h2, 16'h0010)});
    host.send(cw(HCDP_CMD_WRITE, 3'h2, 16'h0010));
    hs(cw(HCDP_CMD_ASYNC, 3'h0, 16'h0));
    for (int b = 2; b < 8; b++) begin
      a = 16'($urandom);
      q_bus.push_back({12'h0, 1'b0, b[2:0], cw(HCDP_CMD_WRITE, b[2:0], a)});
      hs(cw(HCDP_CMD_WRITE, b[2:0], a));
    end
    seq_enabled_i <= 1'b1;
    foreach (lcl[i]) begin
      if (lcl[i] inside {[16'h1000:16'h1bff]}) q_den.push_back(48'h1);
      else q_loc.push_back({lcl[i], cw(HCDP_CMD_WRITE, 3'h1, lcl[i])});
      hs(cw(HCDP_CMD_WRITE, 3'h1, lcl[i]));
    end
    q_den.push_back(48'h1);
    hs(cw(HCDP_CMD_READ, 3'h1, 16'h1bff));
    wait_drain();
    seq_enabled_i <= 1'b0;
    a = 16'($urandom);
    q_st.push_back({40'h0, a[7:0]});
    hs(cw(HCDP_CMD_START, 3'h0, {8'h0, a[7:0]}));
    seq_bus_owned_i <= 1'b1;
    a = 16'($urandom);
    hs(cw(HCDP_CMD_WRITE, 3'h5, a));
    repeat (20) @(posedge ref_clk_i);
    q_bus.push_back({12'h0, 1'b0, 3'h5, cw(HCDP_CMD_WRITE, 3'h5, a)});
    seq_bus_owned_i <= 1'b0;
    for (int b = 2; b < 5; b++) begin
      a = 16'($urandom);
      q_bus.push_back({12'h0, 1'b1, b[2:0], 16'h0, a});
      hs(cw(HCDP_CMD_READ, b[2:0], a));
    end
    // Local read: the return word follows its echo as a message
    rd_hold <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    hs(cw(HCDP_CMD_READ, 3'h1, 16'h0100));
    q_echo.push_back({16'h0, local_rdata_i});
    wait_drain();
    for (int d = 0; d < 2; d++) begin
      double_pixel_enable_i <= d[0];
      @(posedge ref_clk_i);
      for (int k = 0; k < 8; k++) begin
        bw = 48'({$urandom, $urandom});
        pixel_burst_i <= 1'b1;
        pixel_bus_word_i <= bw;
        q_pix.push_back(pix32(bw, d[0]));
        @(posedge ref_clk_i);
      end
      pixel_burst_i <= 1'b0;
      wait_drain();
    end
    end_of_test();
  end
endmodule
